// ### hdl/svdd_top.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "svdd_defs.svh"

module svdd_top #(
  parameter int SETTLE_CYCLES =
    (`SVDD_SETTLE_NS * 1000 + `SVDD_CLK_PS - 1) / `SVDD_CLK_PS
) (
  input  wire logic                  MCLK_I,
  input  wire logic                  ARST_N_I,
  input  wire svdd_pkg::svdd_addr_type ADDR_I,
  input  wire svdd_pkg::svdd_byte_type WDATA_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  output logic [7:0]                 RDATA_O,
  input  wire logic [`SVDD_TAPS-1:0] TAP_AT_OR_ABOVE_I,
  input  wire logic [`SVDD_TAPS-1:0] TAP_AT_OR_BELOW_I,
  input  wire logic                  EXT_AT_OR_ABOVE_I,
  input  wire logic                  EXT_AT_OR_BELOW_I,
  input  wire logic                  SLEEP_I,
  output logic                       DETECTOR_POWER_O,
  output logic [3:0]                 TAP_SELECT_O,
  output logic                       EXT_TRIP_SELECT_O,
  output logic                       REF_STABLE_O,
  output logic                       WAKE_O,
  output logic                       IRQ_O
);
  import svdd_pkg::*;

  localparam int CNT_W = (SETTLE_CYCLES < 2) ? 1 : $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO    = '0;
  localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

  // picks one ladder tap by level code; codes past the last tap give 0
  function automatic logic tap_pick(
    input logic [`SVDD_TAPS-1:0] taps,
    input svdd_level_type        level
  );
    logic hit;
    hit = 1'b0;
    if (level < 4'(`SVDD_TAPS)) begin
      hit = taps[level];
    end
    return hit;
  endfunction

  // one register select; every decode goes through here so they agree
  function automatic logic addr_hit(
    input svdd_addr_type addr,
    input svdd_addr_type code
  );
    logic hit;
    hit = (addr == code);
    return hit;
  endfunction

  // a one-bit field: loads on its own write strobe, else holds
  function automatic logic load_bit(
    input logic strobe,
    input logic value,
    input logic current
  );
    logic bit_next;
    bit_next = current;
    if (strobe) begin
      bit_next = value;
    end
    return bit_next;
  endfunction

  // sticky flag; the set term comes last so it wins a same-cycle clear
  function automatic logic sticky_next(
    input logic set,
    input logic clear,
    input logic current
  );
    logic flag;
    flag = current & ~clear;
    if (set) begin
      flag = 1'b1;
    end
    return flag;
  endfunction

  // a byte holding one bit at pos and zeros elsewhere
  function automatic svdd_byte_type bit_image(
    input int   pos,
    input logic value
  );
    svdd_byte_type image;
    image      = `SVDD_BYTE_ZERO;
    image[pos] = value;
    return image;
  endfunction

  // read-back select; an unmapped address reads as zero
  function automatic svdd_byte_type read_pick(
    input logic          hit_ctrl,
    input logic          hit_flag,
    input logic          hit_irq_en,
    input logic          hit_irq_ctrl,
    input svdd_byte_type img_ctrl,
    input svdd_byte_type img_flag,
    input svdd_byte_type img_irq_en,
    input svdd_byte_type img_irq_ctrl
  );
    svdd_byte_type data;
    data = `SVDD_BYTE_ZERO;
    if (hit_ctrl) begin
      data = img_ctrl;
    end else if (hit_flag) begin
      data = img_flag;
    end else if (hit_irq_en) begin
      data = img_irq_en;
    end else if (hit_irq_ctrl) begin
      data = img_irq_ctrl;
    end
    return data;
  endfunction

  // control register fields
  logic           dir_reg;
  logic           dir_next;
  logic           enable_reg;
  logic           enable_next;
  svdd_level_type level_reg;
  svdd_level_type level_next;

  // settling timer and stable flag
  svdd_state_type   state_reg;
  svdd_state_type   state_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // interrupt side
  logic event_flag_reg;
  logic event_flag_next;
  logic event_irq_en_reg;
  logic event_irq_en_next;
  logic global_en_reg;
  logic global_en_next;

  // read port and wake
  svdd_byte_type rdata_reg;
  svdd_byte_type rdata_next;
  logic          wake_reg;
  logic          wake_next;

  // decode
  wire sel_ctrl     = addr_hit(ADDR_I, `SVDD_ADDR_CTRL);
  wire sel_flag     = addr_hit(ADDR_I, `SVDD_ADDR_FLAG);
  wire sel_irq_en   = addr_hit(ADDR_I, `SVDD_ADDR_IRQ_EN);
  wire sel_irq_ctrl = addr_hit(ADDR_I, `SVDD_ADDR_IRQ_CTRL);

  wire wr_ctrl     = WR_I & sel_ctrl;
  wire wr_flag     = WR_I & sel_flag;
  wire wr_irq_en   = WR_I & sel_irq_en;
  wire wr_irq_ctrl = WR_I & sel_irq_ctrl;

  wire stable = (state_reg == SVDD_ARMED);

  // control register image; bit 6 is hard zero
  svdd_byte_type ctrl_image;
  always_comb begin
    ctrl_image = `SVDD_BYTE_ZERO;
    ctrl_image[`SVDD_DIR_BIT]    = dir_reg;
    ctrl_image[`SVDD_UNIMP_BIT]  = 1'b0;
    ctrl_image[`SVDD_STABLE_BIT] = stable;
    ctrl_image[`SVDD_ENABLE_BIT] = enable_reg;
    ctrl_image[`SVDD_LEVEL_MSB:`SVDD_LEVEL_LSB] = level_reg;
  end

  wire svdd_byte_type flag_image =
    bit_image(`SVDD_EVENT_BIT, event_flag_reg);
  wire svdd_byte_type irq_en_image =
    bit_image(`SVDD_EVENT_BIT, event_irq_en_reg);
  wire svdd_byte_type irq_ctrl_image =
    bit_image(`SVDD_GLOBAL_BIT, global_en_reg);

  wire svdd_byte_type read_mux = read_pick(
    sel_ctrl, sel_flag, sel_irq_en, sel_irq_ctrl,
    ctrl_image, flag_image, irq_en_image, irq_ctrl_image);

  // control writes; bit 6 and bit 5 of the write data are dropped
  wire wr_dir_bit    = WDATA_I[`SVDD_DIR_BIT];
  wire wr_enable_bit = WDATA_I[`SVDD_ENABLE_BIT];
  wire wr_event_bit  = WDATA_I[`SVDD_EVENT_BIT];
  wire wr_global_bit = WDATA_I[`SVDD_GLOBAL_BIT];

  assign dir_next    = load_bit(wr_ctrl, wr_dir_bit, dir_reg);
  assign enable_next = load_bit(wr_ctrl, wr_enable_bit, enable_reg);
  assign level_next  = wr_ctrl ?
    WDATA_I[`SVDD_LEVEL_MSB:`SVDD_LEVEL_LSB] : level_reg;

  // comparator selection; 1111 routes the external input instead
  wire ext_mode = (level_reg == `SVDD_LEVEL_EXT);
  wire hit_above = ext_mode ? EXT_AT_OR_ABOVE_I :
                   tap_pick(TAP_AT_OR_ABOVE_I, level_reg);
  wire hit_below = ext_mode ? EXT_AT_OR_BELOW_I :
                   tap_pick(TAP_AT_OR_BELOW_I, level_reg);
  wire crossing  = dir_reg ? hit_above
                           : hit_below;

  // settling timer: a fixed number of cycles derived from a time, so the
  // interval stays the same length in ns whatever the firmware does
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      SVDD_OFF: begin
        count_next = CNT_ZERO;
        if (enable_reg) begin
          state_next = SVDD_SETTLE;
        end
      end
      SVDD_SETTLE: begin
        count_next = count_reg + CNT_ONE;
        if (count_reg == SETTLE_LAST) begin
          state_next = SVDD_ARMED;
        end
      end
      SVDD_ARMED: begin
        count_next = CNT_ZERO;
      end
      default: begin
        state_next = SVDD_OFF;
        count_next = CNT_ZERO;
      end
    endcase
    // disabling drops the stable flag at once and restarts later
    if (!enable_reg) begin
      state_next = SVDD_OFF;
      count_next = CNT_ZERO;
    end
  end

  // an event needs enable, a settled reference and a live crossing
  wire event_hit = enable_reg & stable & crossing;

  // set wins over a write-one clear in the same cycle
  wire flag_clear = wr_flag & wr_event_bit;
  assign event_flag_next =
    sticky_next(event_hit, flag_clear, event_flag_reg);

  assign event_irq_en_next =
    load_bit(wr_irq_en, wr_event_bit, event_irq_en_reg);
  assign global_en_next =
    load_bit(wr_irq_ctrl, wr_global_bit, global_en_reg);

  // read data stand only in the cycle after the strobe
  assign rdata_next = RD_I ? read_mux : `SVDD_BYTE_ZERO;

  // wake pulse when a new event lands during sleep
  assign wake_next = SLEEP_I & event_hit & ~event_flag_reg;

  // control register; reset leaves the detector powered down
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dir_reg <= `SVDD_DIR_RESET;
    end else begin
      dir_reg <= dir_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      enable_reg <= `SVDD_ENABLE_RESET;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      level_reg <= `SVDD_LEVEL_RESET;
    end else begin
      level_reg <= level_next;
    end
  end

  // settling timer
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= SVDD_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      count_reg <= CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  // interrupt side
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      event_flag_reg <= 1'b0;
    end else begin
      event_flag_reg <= event_flag_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      event_irq_en_reg <= 1'b0;
    end else begin
      event_irq_en_reg <= event_irq_en_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      global_en_reg <= 1'b0;
    end else begin
      global_en_reg <= global_en_next;
    end
  end

  // read port and wake
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_reg <= `SVDD_BYTE_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
    end
  end

  // analog side follows the control register directly
  assign DETECTOR_POWER_O  = enable_reg;
  assign TAP_SELECT_O      = level_reg;
  assign EXT_TRIP_SELECT_O = ext_mode & enable_reg;
  assign REF_STABLE_O      = stable;
  assign RDATA_O           = rdata_reg;
  assign WAKE_O            = wake_reg;

  // level interrupt; the flag still sets with the enables off
  assign IRQ_O = event_flag_reg & event_irq_en_reg & global_en_reg;

endmodule
`default_nettype wire

// ### common/svdd_defs.svh
`ifndef SVDD_DEFS_SVH
`define SVDD_DEFS_SVH

// register offsets on the plain register port
`define SVDD_ADDR_CTRL      4'h0
`define SVDD_ADDR_FLAG      4'h1
`define SVDD_ADDR_IRQ_EN    4'h2
`define SVDD_ADDR_IRQ_CTRL  4'h3

// voltage_detect_control fields
`define SVDD_DIR_BIT        7
`define SVDD_UNIMP_BIT      6
`define SVDD_STABLE_BIT     5
`define SVDD_ENABLE_BIT     4
`define SVDD_LEVEL_MSB      3
`define SVDD_LEVEL_LSB      0
`define SVDD_LEVEL_EXT      4'hF
`define SVDD_DIR_RESET      1'h0
`define SVDD_ENABLE_RESET   1'h0
`define SVDD_LEVEL_RESET    4'h5

// event flag and its per-event interrupt enable share one bit position
`define SVDD_EVENT_BIT      2
// global enable in the irq control register
`define SVDD_GLOBAL_BIT     7

`define SVDD_BYTE_ZERO      8'h00
`define SVDD_TAPS           15

// settling interval in ns, clock period in ps
`define SVDD_SETTLE_NS      20000
`define SVDD_CLK_PS         4000

`endif

// ### common/svdd_pkg.sv
`default_nettype none
package svdd_pkg;

  typedef logic [7:0] svdd_byte_type;
  typedef logic [3:0] svdd_addr_type;
  typedef logic [3:0] svdd_level_type;

  typedef enum logic [1:0] {
    SVDD_OFF     = 2'b00,
    SVDD_SETTLE  = 2'b01,
    SVDD_ARMED   = 2'b10
  } svdd_state_type;

endpackage
`default_nettype wire

// ### tb/svdd_checker.sv
`timescale 1ns/10ps
`default_nettype none
module svdd_checker #(
  parameter int SETTLE_CYCLES = 5000
) (
  input wire logic                    MCLK_I,
  input wire logic                    ARST_N_I,
  input wire svdd_pkg::svdd_addr_type ADDR_I,
  input wire svdd_pkg::svdd_byte_type WDATA_I,
  input wire logic                    WR_I,
  input wire logic                    RD_I,
  input wire logic [7:0]              RDATA_O,
  input wire logic                    SLEEP_I,
  input wire logic                    DETECTOR_POWER_O,
  input wire logic [3:0]              TAP_SELECT_O,
  input wire logic                    EXT_TRIP_SELECT_O,
  input wire logic                    REF_STABLE_O,
  input wire logic                    WAKE_O,
  input wire logic                    IRQ_O
);
  import svdd_pkg::*;
  // cycles the detector has been powered, saturating just past settle
  logic [15:0] on_cnt_reg;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) on_cnt_reg <= 16'h0000;
    else if (!DETECTOR_POWER_O) on_cnt_reg <= 16'h0000;
    else if (on_cnt_reg <= 16'(SETTLE_CYCLES)) on_cnt_reg <= on_cnt_reg + 16'h0001;
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_ctrl_wr; WR_I && ADDR_I == 4'h0; endsequence
  sequence s_ctrl_rd; RD_I && ADDR_I == 4'h0; endsequence
  property p_unimp; s_ctrl_rd |=> !RDATA_O[6]; endproperty
  a_unimp: assert property (p_unimp)
    else $error("control bit 6 read as one");
  property p_stable_rd;
    s_ctrl_rd |=> RDATA_O[5] == $past(REF_STABLE_O)
      && RDATA_O[4] == $past(DETECTOR_POWER_O);
  endproperty
  a_stable_rd: assert property (p_stable_rd)
    else $error("control read disagrees with stable or enable");
  property p_power; s_ctrl_wr |=> DETECTOR_POWER_O == $past(WDATA_I[4]); endproperty
  a_power: assert property (p_power)
    else $error("detector power does not follow enable write");
  property p_level; s_ctrl_wr |=> TAP_SELECT_O == $past(WDATA_I[3:0]); endproperty
  a_level: assert property (p_level)
    else $error("tap select does not follow level write");
  property p_ext;
    EXT_TRIP_SELECT_O == (DETECTOR_POWER_O && TAP_SELECT_O == 4'hF);
  endproperty
  a_ext: assert property (p_ext)
    else $error("external trip select wrong");
  property p_settle; REF_STABLE_O == (on_cnt_reg > 16'(SETTLE_CYCLES)); endproperty
  a_settle: assert property (p_settle)
    else $error("stable flag timing wrong");
  property p_gbl_off; WR_I && ADDR_I == 4'h3 && !WDATA_I[7] |=> !IRQ_O; endproperty
  a_gbl_off: assert property (p_gbl_off)
    else $error("interrupt high with global enable clear");
  property p_wake; WAKE_O |-> $past(SLEEP_I) && !$past(WAKE_O); endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse without sleep or too long");
endmodule
bind svdd_top svdd_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .SLEEP_I(SLEEP_I),
  .DETECTOR_POWER_O(DETECTOR_POWER_O), .TAP_SELECT_O(TAP_SELECT_O),
  .EXT_TRIP_SELECT_O(EXT_TRIP_SELECT_O), .REF_STABLE_O(REF_STABLE_O),
  .WAKE_O(WAKE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ### tb/svdd_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module svdd_top_tb;
  import svdd_pkg::*;
  logic          clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic          sleep = 1'b0, ext_hi = 1'b0, ext_lo = 1'b0;
  svdd_addr_type addr = 4'h0;
  svdd_byte_type wdata = 8'h00;
  logic [14:0]   hi = 15'h0000, lo = 15'h0000;
  logic [7:0]    rdata;
  logic [3:0]    tap;
  logic          pwr, ext_sel, stable, wake, irq;
  int            err_total = 0, num_checks = 0;
  always #2 clk = ~clk;
  svdd_top #(.SETTLE_CYCLES(8)) DUT (
    .MCLK_I(clk), .ARST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TAP_AT_OR_ABOVE_I(hi),
    .TAP_AT_OR_BELOW_I(lo), .EXT_AT_OR_ABOVE_I(ext_hi),
    .EXT_AT_OR_BELOW_I(ext_lo), .SLEEP_I(sleep), .DETECTOR_POWER_O(pwr),
    .TAP_SELECT_O(tap), .EXT_TRIP_SELECT_O(ext_sel), .REF_STABLE_O(stable),
    .WAKE_O(wake), .IRQ_O(irq));
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string w, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(w, rdata, e);
  endtask
  task automatic drive(input logic [14:0] h, l, input logic eh);
    @(posedge clk);
    hi <= h;
    lo <= l;
    ext_hi <= eh;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctrl", 4'h0, 8'h05);
    rd_chk("flag", 4'h1, 8'h00);
    wr_reg(4'h9, 8'hFF);
    rd_chk("unmapped", 4'h9, 8'h00);
    chk("tap", {4'h0, tap}, 8'h05);
    wr_reg(4'h0, 8'hFF);
    rd_chk("ctrl", 4'h0, 8'h9F);
    chk("ext sel", {7'h00, ext_sel}, 8'h01);
    chk("power", {7'h00, pwr}, 8'h01);
    $display("done reset and control");
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h0, 8'h03);
    wr_reg(4'h0, 8'h13);
    drive(15'h0000, 15'h0008, 1'b0);
    rd_chk("flag", 4'h1, 8'h00);
    repeat (10) @(posedge clk);
    rd_chk("ctrl", 4'h0, 8'h33);
    rd_chk("flag", 4'h1, 8'h04);
    wr_reg(4'h2, 8'h04);
    wr_reg(4'h3, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(4'h3, 8'h80);
    chk("irq", {7'h00, irq}, 8'h01);
    wr_reg(4'h1, 8'h04);
    rd_chk("flag", 4'h1, 8'h04);
    drive(15'h0008, 15'h0000, 1'b0);
    wr_reg(4'h1, 8'h04);
    rd_chk("flag", 4'h1, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(4'h0, 8'h93);
    rd_chk("flag", 4'h1, 8'h04);
    $display("done settle and events");
    for (int k = 0; k < 16; k++) begin
      drive(15'h0000, 15'h0000, 1'b0);
      wr_reg(4'h1, 8'h04);
      wr_reg(4'h0, {4'h9, k[3:0]});
      drive((k < 15) ? (15'h0001 << k) : 15'h0000, 15'h0000, k == 15);
      rd_chk("level flag", 4'h1, 8'h04);
    end
    drive(15'h0000, 15'h0000, 1'b0);
    wr_reg(4'h1, 8'h04);
    $display("done levels");
    @(posedge clk);
    sleep <= 1'b1;
    ext_hi <= 1'b1;
    @(posedge clk);
    #1 chk("wake", {7'h00, wake}, 8'h01);
    @(posedge clk);
    #1 chk("wake", {7'h00, wake}, 8'h00);
    sleep <= 1'b0;
    drive(15'h0000, 15'h0000, 1'b0);
    wr_reg(4'h0, 8'h0F);
    @(posedge clk);
    #1 chk("stable", {7'h00, stable}, 8'h00);
    chk("power", {7'h00, pwr}, 8'h00);
    wr_reg(4'h1, 8'h04);
    drive(15'h0000, 15'h0000, 1'b1);
    rd_chk("flag", 4'h1, 8'h00);
    drive(15'h0000, 15'h0000, 1'b0);
    wr_reg(4'h0, 8'h1F);
    rd_chk("ctrl", 4'h0, 8'h1F);
    $display("done sleep and disable");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctrl", 4'h0, 8'h05);
    $display("done second reset");
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
`default_nettype wire
